// ===== hdl/bfs_flag_cell.sv
// one sticky fault flag plus its interrupt-pending bit.
// assumes fault_seen is already synchronous to aclk.
`timescale 1ns/100ps
`default_nettype none
module bfs_flag_cell #(
  parameter bit PAIR_CLEARS_PIN = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fault_seen,
  input wire logic pair_clear,
  input wire logic pend_clear,
  output logic flag,
  output logic pending
);

  logic flag_reg;
  logic flag_next;
  logic pend_reg;
  logic pend_next;
  logic pend_drop;

  // set beats clear so a fault in the clearing cycle is kept
  assign flag_next = fault_seen | (flag_reg & ~pair_clear);
  assign pend_drop = pend_clear | (PAIR_CLEARS_PIN & pair_clear);
  assign pend_next = fault_seen | (pend_reg & ~pend_drop);

  // state update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      pend_reg <= pend_next;
    end
  end

  assign flag = flag_reg;
  assign pending = pend_reg;

endmodule
`default_nettype wire

// ===== hdl/bfs_pkg.sv
// package for the boost fault status bank: register map, field layout,
// reset values and bus answer codes.
// assumes an AXI4-Lite slave with 32-bit data and byte addressing.
package bfs_pkg;

  // bus widths
  localparam int BFS_ADDR_W = 8;
  localparam int BFS_DATA_W = 32;
  localparam int BFS_STRB_W = BFS_DATA_W / 8;

  // register byte addresses
  localparam logic [BFS_ADDR_W-1:0] BFS_FLAGS_OFS = 8'h10;
  localparam logic [BFS_ADDR_W-1:0] BFS_PEND_OFS = 8'h18;
  localparam logic [BFS_ADDR_W-1:0] BFS_MASK_OFS = 8'h1C;
  // word select drops the two byte-offset bits
  localparam int BFS_WORD_LSB = 2;

  // eight faults, each a flag bit over its clear bit
  localparam int BFS_NUM_FAULTS = 8;
  localparam int BFS_FLAGS_W = 2 * BFS_NUM_FAULTS;

  // fault index i sits at flag bit 2i+1 and clear bit 2i
  localparam int BFS_F_OVERTEMP = 7;
  localparam int BFS_F_CURRENT_RES_SHORT = 6;
  localparam int BFS_F_LED_CFG_RES_MISSING = 5;
  localparam int BFS_F_MODE_RES_MISSING = 4;
  localparam int BFS_F_FREQ_RES_MISSING = 3;
  localparam int BFS_F_BOOST_OVERCURRENT = 2;
  localparam int BFS_F_BOOST_OVERVOLT_HI = 1;
  localparam int BFS_F_BOOST_OVERVOLT_LO = 0;

  // reset values
  localparam logic [BFS_FLAGS_W-1:0] BFS_FLAGS_RESET = 16'h0000;
  localparam logic [BFS_NUM_FAULTS-1:0] BFS_PEND_RESET = 8'h00;
  localparam logic [BFS_NUM_FAULTS-1:0] BFS_MASK_RESET = 8'h00;
  localparam logic [BFS_DATA_W-1:0] BFS_RDATA_ZERO = 32'h0000_0000;

  // AXI response codes
  localparam logic [1:0] BFS_RESP_OKAY = 2'h0;
  localparam logic [1:0] BFS_RESP_SLVERR = 2'h2;

endpackage

// ===== hdl/bfs_status_bank.sv
// boost fault status bank: sticky fault flags with paired clear bits,
// an interrupt pending/mask pair and an AXI4-Lite register slave.
// assumes fault detector levels arrive asynchronously and are synced here;
// one clock, synchronous active-low reset.
//
// Operation
// - 16-bit flag register at 0x10, resets zero
// - bit 15 overtemp flag, bit 14 clear
// - bit 13 current resistor short, 12 clear
// - bit 11 led config resistor missing, 10 clear
// - bit 9 mode resistor missing, 8 clear
// - bit 7 freq resistor missing, 6 clear
// - bit 5 boost overcurrent, 4 clear
// - bit 3 boost overvolt high, 2 clear
// - bit 1 boost overvolt low, 0 clear
// - flag plus clear in one write clears flag, pin
// - low overvolt pair write clears flag only
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module bfs_status_bank
  import bfs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // fault detector levels, one per fault index
  input wire logic [bfs_pkg::BFS_NUM_FAULTS-1:0] fault_detect,
  // write address channel
  input wire logic awvalid,
  output logic awready,
  input wire logic [bfs_pkg::BFS_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // write data channel
  input wire logic wvalid,
  output logic wready,
  input wire logic [bfs_pkg::BFS_DATA_W-1:0] wdata,
  input wire logic [bfs_pkg::BFS_STRB_W-1:0] wstrb,
  // write response channel
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read address channel
  input wire logic arvalid,
  output logic arready,
  input wire logic [bfs_pkg::BFS_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // read data channel
  output logic rvalid,
  input wire logic rready,
  output logic [bfs_pkg::BFS_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // flag levels for the rest of the chip
  output logic [bfs_pkg::BFS_NUM_FAULTS-1:0] fault_flags,
  // level interrupt toward the fault pin driver
  output logic fault_irq
);

  import bfs_pkg::*;

  // fault synchroniser stages
  logic [BFS_NUM_FAULTS-1:0] det_meta_reg;
  logic [BFS_NUM_FAULTS-1:0] det_sync_reg;

  // write path holding state
  logic aw_held_reg;
  logic [BFS_ADDR_W-1:0] aw_addr_reg;
  logic w_held_reg;
  logic [BFS_DATA_W-1:0] w_data_reg;
  logic [BFS_STRB_W-1:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;

  // read path state
  logic rvalid_reg;
  logic [BFS_DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;

  // mask register
  logic [BFS_NUM_FAULTS-1:0] mask_reg;
  logic [BFS_NUM_FAULTS-1:0] mask_next;

  // per-fault cell outputs and controls
  logic [BFS_NUM_FAULTS-1:0] flag_bits;
  logic [BFS_NUM_FAULTS-1:0] pend_bits;
  logic [BFS_NUM_FAULTS-1:0] pair_clear;
  logic [BFS_NUM_FAULTS-1:0] pend_clear;

  // decode and selection wires
  wire aw_fire;
  wire w_fire;
  wire ar_fire;
  wire do_write;
  wire [BFS_ADDR_W-1:0] wr_word_addr;
  wire [BFS_ADDR_W-1:0] rd_word_addr;
  wire wr_flags_hit;
  wire wr_pend_hit;
  wire wr_mask_hit;
  wire wr_mapped;
  wire rd_flags_hit;
  wire rd_pend_hit;
  wire rd_mask_hit;
  wire rd_mapped;
  wire [BFS_DATA_W-1:0] lane_mask;
  wire [BFS_DATA_W-1:0] wr_eff;
  wire [BFS_FLAGS_W-1:0] flags_view;
  wire [BFS_DATA_W-1:0] rd_value;

  // two-flop synchroniser; only the second stage is read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      det_meta_reg <= BFS_PEND_RESET;
      det_sync_reg <= BFS_PEND_RESET;
    end else begin
      det_meta_reg <= fault_detect;
      det_sync_reg <= det_meta_reg;
    end
  end

  // channel handshakes; one write and one read in flight at most
  assign awready = ~aw_held_reg & ~bvalid_reg;
  assign wready = ~w_held_reg & ~bvalid_reg;
  assign arready = ~rvalid_reg;
  assign aw_fire = awvalid & awready;
  assign w_fire = wvalid & wready;
  assign ar_fire = arvalid & arready;
  // the write acts once both halves are held, so the order is free
  assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;

  // address decode on word boundaries
  assign wr_word_addr = {aw_addr_reg[BFS_ADDR_W-1:BFS_WORD_LSB], 2'h0};
  assign rd_word_addr = {araddr[BFS_ADDR_W-1:BFS_WORD_LSB], 2'h0};
  assign wr_flags_hit = (wr_word_addr == BFS_FLAGS_OFS);
  assign wr_pend_hit = (wr_word_addr == BFS_PEND_OFS);
  assign wr_mask_hit = (wr_word_addr == BFS_MASK_OFS);
  assign wr_mapped = wr_flags_hit | wr_pend_hit | wr_mask_hit;
  assign rd_flags_hit = (rd_word_addr == BFS_FLAGS_OFS);
  assign rd_pend_hit = (rd_word_addr == BFS_PEND_OFS);
  assign rd_mask_hit = (rd_word_addr == BFS_MASK_OFS);
  assign rd_mapped = rd_flags_hit | rd_pend_hit | rd_mask_hit;

  // byte enables gate the written data lane by lane
  genvar gl;
  generate
    for (gl = 0; gl < BFS_STRB_W; gl = gl + 1) begin : g_lane
      assign lane_mask[gl*8 +: 8] = {8{w_strb_reg[gl]}};
    end
  endgenerate
  assign wr_eff = w_data_reg & lane_mask;

  // per-fault clear decode, flag cells and read view
  genvar gf;
  generate
    for (gf = 0; gf < BFS_NUM_FAULTS; gf = gf + 1) begin : g_fault
      // both bits of the pair in one write, else nothing happens
      assign pair_clear[gf] = do_write & wr_flags_hit
        & wr_eff[2*gf+1] & wr_eff[2*gf];
      assign pend_clear[gf] = do_write & wr_pend_hit & wr_eff[gf];
      // clear bits are actions, so they read back as zero
      assign flags_view[2*gf+1] = flag_bits[gf];
      assign flags_view[2*gf] = 1'b0;
      // low overvolt pair write leaves the pending bit alone
      bfs_flag_cell #(
        .PAIR_CLEARS_PIN(gf != BFS_F_BOOST_OVERVOLT_LO)
      ) u_cell (
        .aclk(aclk),
        .aresetn(aresetn),
        .fault_seen(det_sync_reg[gf]),
        .pair_clear(pair_clear[gf]),
        .pend_clear(pend_clear[gf]),
        .flag(flag_bits[gf]),
        .pending(pend_bits[gf])
      );
    end
  endgenerate

  // fault bit placement in the flag word
  // overtemp at 15/14
  // current resistor short at 13/12
  // led config resistor missing at 11/10
  // mode resistor missing at 9/8
  // freq resistor missing at 7/6
  // boost overcurrent at 5/4
  // boost overvolt high at 3/2
  // boost overvolt low at 1/0

  // mask takes the low byte lane only
  assign mask_next = wr_eff[BFS_NUM_FAULTS-1:0];

  // read mux; unused upper bits read zero
  assign rd_value = rd_flags_hit ? {{(BFS_DATA_W-BFS_FLAGS_W){1'b0}}, flags_view}
    : rd_pend_hit ? {{(BFS_DATA_W-BFS_NUM_FAULTS){1'b0}}, pend_bits}
    : rd_mask_hit ? {{(BFS_DATA_W-BFS_NUM_FAULTS){1'b0}}, mask_reg}
    : BFS_RDATA_ZERO;

  // write address and data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= BFS_FLAGS_OFS;
    end else if (aw_fire) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= BFS_RDATA_ZERO;
      w_strb_reg <= '0;
    end else if (w_fire) begin
      w_held_reg <= 1'b1;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  // write response; unmapped addresses get an error answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= BFS_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? BFS_RESP_OKAY : BFS_RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // mask register update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= BFS_MASK_RESET;
    end else if (do_write & wr_mask_hit) begin
      mask_reg <= mask_next;
    end
  end

  // read data registered on address acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= BFS_RDATA_ZERO;
      rresp_reg <= BFS_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_value;
      rresp_reg <= rd_mapped ? BFS_RESP_OKAY : BFS_RESP_SLVERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // outputs
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign fault_flags = flag_bits;
  // pin follows the masked pending bits, so a pair clear drops it too, except the low overvolt pair write
  assign fault_irq = |(pend_bits & mask_reg);

endmodule
`default_nettype wire

// ===== sim/bfs_status_bank_props.sv
// checker for the boost fault status bank, bound to its ports.
// assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module bfs_status_bank_props
  import bfs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [bfs_pkg::BFS_NUM_FAULTS-1:0] fault_detect,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [bfs_pkg::BFS_NUM_FAULTS-1:0] fault_flags,
  input wire logic fault_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a fault seen at an edge passes two sync stages and lands one edge later
  property p_flag_set;
    $past(aresetn, 3) && $past(aresetn, 2) && $past(aresetn) |->
      ($past(fault_detect, 3) & ~fault_flags) == 8'h00;
  endproperty
  chk_flag_set: assert property (p_flag_set)
    else $error("flag missed a held fault");
  // a flag can only fall on an applied write, which always raises bvalid next
  chk_flags_stay: assert property ($past(aresetn) && !bvalid |->
    ($past(fault_flags) & ~fault_flags) == 8'h00)
    else $error("flag fell with no write");
  chk_write_answer: assert property (awvalid & awready & wvalid & wready |-> ##2 bvalid)
    else $error("write answer late");
  chk_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  chk_b_single: assert property (bvalid && bready |=> !bvalid)
    else $error("write answer repeated");
  chk_ar_block: assert property (rvalid |-> !arready)
    else $error("read taken while busy");
  chk_aw_block: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while busy");
  // mask resets to zero, so the pin is quiet right after reset
  chk_irq_quiet: assert property (!$past(aresetn) |-> !fault_irq)
    else $error("interrupt after reset");
  cover property (fault_irq);
  cover property (bvalid && bready);
  cover property (rvalid && rready);
endmodule
bind bfs_status_bank bfs_status_bank_props u_props (.aclk, .aresetn, .fault_detect, .awvalid,
  .awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready,
  .fault_flags, .fault_irq);
`default_nettype wire

// ===== sim/bfs_status_bank_tb.sv
// self-checking bench for the boost fault status bank.
// assumes the bank answers on AXI4-Lite with one clock at 20 MHz.
`timescale 1ns/100ps
`default_nettype none
module bfs_status_bank_tb;
  import bfs_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, fault_irq;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, fault_detect = 8'h00, fault_flags;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'h6ECF6C43, rv;
  logic [3:0] wstrb = 4'hF;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [1:0] bresp, rresp;
  int mismatches = 0, checked = 0;
  bfs_status_bank dut (.aclk, .aresetn, .fault_detect, .awvalid, .awready, .awaddr, .awprot,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .arprot, .rvalid, .rready, .rdata, .rresp, .fault_flags, .fault_irq);
  // 50 ns period
  always #25 aclk = ~aclk;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // flag i sits at bit 2i+1, its clear bit just below
  function automatic logic [31:0] spread(input logic [7:0] f);
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < 8; i++) v[2*i+1] = f[i];
    return v;
  endfunction
  function automatic logic [31:0] pairs(input logic [7:0] f);
    return spread(f) | (spread(f) >> 1);
  endfunction
  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // bounded waits: a stuck answer ends the run
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    bit done;
    int n;
    done = 0;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < 50) begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1;
        check({30'h0, bresp}, {30'h0, er});
      end
    end
    if (!done) begin
      mismatches++;
      test_done;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = 2'h0);
    bit done;
    int n;
    done = 0;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 50) begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1;
        check(rdata, ed);
        check({30'h0, rresp}, {30'h0, er});
      end
    end
    if (!done) begin
      mismatches++;
      test_done;
    end
  endtask
  // detector levels take three edges to land, two more to leave the sync
  task automatic pulse(input logic [7:0] f);
    fault_detect <= f;
    repeat (4) @(posedge aclk);
    fault_detect <= 8'h00;
    repeat (2) @(posedge aclk);
  endtask
  task automatic irq_is(input logic b);
    @(posedge aclk);
    check({31'h0, fault_irq}, {31'h0, b});
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(BFS_FLAGS_OFS, 32'h0);
    rd(BFS_MASK_OFS, 32'h0);
    rd(8'h20, 32'h0, BFS_RESP_SLVERR);
    wr(8'h20, 32'hFFFF, BFS_RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i);
      check({24'h0, fault_flags}, {24'h0, 8'h01 << i});
      rd(BFS_FLAGS_OFS, spread(8'h01 << i));
      wr(BFS_FLAGS_OFS, spread(8'h01 << i));
      wr(BFS_FLAGS_OFS, spread(8'h01 << i) >> 1);
      rd(BFS_FLAGS_OFS, spread(8'h01 << i));
      wr(BFS_FLAGS_OFS, pairs(8'h01 << i));
      rd(BFS_FLAGS_OFS, 32'h0);
    end
    rd(BFS_PEND_OFS, 32'h1);
    // a clear that meets a live fault loses
    fault_detect <= 8'h80;
    repeat (4) @(posedge aclk);
    wr(BFS_FLAGS_OFS, pairs(8'h80));
    rd(BFS_FLAGS_OFS, spread(8'h80));
    pulse(8'h00);
    wr(BFS_FLAGS_OFS, pairs(8'h80));
    // lane 0 switched off: the pair write for fault 0 must not land
    pulse(8'h01);
    wstrb <= 4'hE;
    wr(BFS_FLAGS_OFS, pairs(8'h01));
    rd(BFS_FLAGS_OFS, spread(8'h01));
    wstrb <= 4'hF;
    wr(BFS_FLAGS_OFS, pairs(8'h01));
    rd(BFS_FLAGS_OFS, 32'h0);
    wr(BFS_PEND_OFS, 32'hFF);
    wr(BFS_MASK_OFS, 32'hFF);
    // corner sets first, then random ones
    for (int k = 0; k < 5; k++) begin
      seed = lfsr(seed);
      rv = (k == 0) ? 32'h1 : (k == 1) ? 32'hFF : {24'h0, seed[7:0]};
      pulse(rv[7:0]);
      irq_is(rv != 0);
      rd(BFS_PEND_OFS, rv);
      wr(BFS_MASK_OFS, 32'h0);
      irq_is(1'b0);
      wr(BFS_MASK_OFS, 32'hFF);
      wr(BFS_FLAGS_OFS, pairs(rv[7:0]));
      rd(BFS_FLAGS_OFS, 32'h0);
      irq_is(rv[0]);
      wr(BFS_PEND_OFS, 32'hFF);
      irq_is(1'b0);
    end
    // reset in mid-run wipes flags and mask
    pulse(8'h5A);
    check({24'h0, fault_flags}, 32'h5A);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(BFS_FLAGS_OFS, 32'h0);
    rd(BFS_MASK_OFS, 32'h0);
    rd(BFS_PEND_OFS, 32'h0);
    irq_is(1'b0);
    test_done;
  end
endmodule
`default_nettype wire
